// >>> pkg/dbgev_defs.svh
`ifndef DBGEV_DEFS_SVH
`define DBGEV_DEFS_SVH
// Overview of operation
// - Value-compare events are synchronous when compare_async_select is 0, asynchronous when 1.
// - Every storage access of one instruction is checked separately for value compare.
// - Only cache_line_zero among cache operations may raise a value-compare event.
// - store_conditional_word without a reservation raises no value-compare write event.
// - String load or store with string_byte_count zero raises no value-compare event.
// - Branch-taken event needs its enable bit and a taken branch attempt.
// - External or wait mode: branch event sets status, suppresses, stops at branch.
// - Internal mode, interrupts allowed: branch event suppresses, debug interrupt, saves branch address.
// - Internal-only mode with interrupts blocked never raises a branch-taken event.
// - Trace mode: branch event sets status, reports on trace, execution continues.
// - Trap event needs its enable bit and a satisfied trap_word instruction attempt.
// - External or wait mode: trap event sets status, suppresses, stops at trap.
// - Internal mode, interrupts allowed: trap event suppresses, debug interrupt, saves trap address.
// - Internal-only, interrupts blocked: trap sets status and imprecise flag, program interrupt, delayed.
// - Trace mode: trap event sets status, reports on trace, execution continues.
// - Exit-handler event needs its enable bit and any of three return instructions.
// - External or wait mode: return event sets status, suppresses, stops at return.
// - Internal mode, interrupts allowed: return suppressed, debug interrupt, saves return address.
// - Internal-only, interrupts blocked: only the non-critical return raises the event.
// - That return sets status and imprecise flag, executes; delayed interrupt follows unless cleared.
// - Trace mode: return event sets status, reports on trace, execution continues.
// - Value-compare events share the per-comparator read or write status bits.

// Register byte offsets
`define DBGEV_OFS_ENABLE   8'h00
`define DBGEV_OFS_MODE     8'h04
`define DBGEV_OFS_VCCTL    8'h08
`define DBGEV_OFS_VALUE1   8'h0c
`define DBGEV_OFS_VALUE2   8'h10
`define DBGEV_OFS_STATUS   8'h14
`define DBGEV_OFS_SAVEPC   8'h18

// Event enable and status bit positions (status bit 7 is the imprecise flag)
`define DBGEV_B_BRANCH 0
`define DBGEV_B_TRAP   1
`define DBGEV_B_EXIT   2
`define DBGEV_B_C1R    3
`define DBGEV_B_C1W    4
`define DBGEV_B_C2R    5
`define DBGEV_B_C2W    6
`define DBGEV_B_IMPR   7
`define DBGEV_EV_MASK  8'h7f

// Mode register bit positions
`define DBGEV_M_EXT   0
`define DBGEV_M_WAIT  1
`define DBGEV_M_INT   2
`define DBGEV_M_TRACE 3

// Value-compare control field positions
`define DBGEV_VC_ASYNC 0
`define DBGEV_VC_BE1   4
`define DBGEV_VC_BE2   8
`define DBGEV_VC_M1    12
`define DBGEV_VC_M2    14

// Comparison modes
`define DBGEV_CMP_AND   2'h1
`define DBGEV_CMP_OR    2'h2
`define DBGEV_CMP_ANDOR 2'h3

// Reset values
`define DBGEV_RST_ZERO 32'h0000_0000
`endif

// >>> pkg/dbgev_pkg.sv
package dbgev_pkg;

  // Instruction classes seen by the event logic
  typedef enum logic [3:0] {
    DBGEV_OP_NONE       = 4'h0,
    DBGEV_OP_BRANCH     = 4'h1,
    DBGEV_OP_TRAP       = 4'h2,
    DBGEV_OP_RFI        = 4'h3,
    DBGEV_OP_RFCI       = 4'h4,
    DBGEV_OP_RFMCI      = 4'h5,
    DBGEV_OP_LOAD       = 4'h6,
    DBGEV_OP_STORE      = 4'h7,
    DBGEV_OP_LINE_ZERO  = 4'h8,
    DBGEV_OP_CACHE_OTH  = 4'h9,
    DBGEV_OP_STCOND     = 4'ha,
    DBGEV_OP_STRING     = 4'hb
  } dbgev_op_t;

  // One instruction attempt from the core
  typedef struct packed {
    logic        valid;
    dbgev_op_t   op;
    logic        cond_ok;   // Branch taken or trap condition true
    logic [31:0] pc;
  } dbgev_instr_t;

  // One storage access; a multi-access instruction sends one per cycle
  typedef struct packed {
    logic        valid;
    dbgev_op_t   op;
    logic        is_write;
    logic        resv_held;     // Reservation present for conditional store
    logic        count_zero;    // String byte count is zero
    logic [1:0]  addr_hit;      // Address comparators 1 and 2 matched
    logic [3:0]  lanes;         // Bytes accessed in the aligned word, bit 0 = lane 0
    logic [31:0] data;          // Lane 0 in bits 31:24
    logic [31:0] pc;
  } dbgev_access_t;

  // Action handed back to the core and trace port
  typedef struct packed {
    logic        suppress;
    logic        stop;
    logic        debug_irq;
    logic        prog_irq;
    logic        trace;
    logic [6:0]  trace_kind;
    logic [31:0] pc;
  } dbgev_action_t;

endpackage

// >>> hw/dbgev_detect.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "dbgev_defs.svh"

module dbgev_detect (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Core side
  input  wire logic                   break_interrupt_allow,
  input  wire dbgev_pkg::dbgev_instr_t  instr,
  input  wire dbgev_pkg::dbgev_access_t acc,
  output dbgev_pkg::dbgev_action_t    action,
  output logic                        delayed_irq
);

  // Software-visible state
  logic [7:0]  debug_event_enable_reg;
  logic [3:0]  mode;
  logic [15:0] value_compare_control_reg;
  logic [31:0] value1;
  logic [31:0] value2;
  logic [7:0]  debug_status_reg;
  logic [31:0] critical_save_pc;
  logic        pending;

  // Mode decode
  logic ext_or_wait;
  logic int_allow;
  logic int_only;
  logic trace_only;
  logic any_mode;
  logic irq_allow;

  assign irq_allow   = break_interrupt_allow;
  assign ext_or_wait = mode[`DBGEV_M_EXT] | mode[`DBGEV_M_WAIT];
  assign int_allow   = mode[`DBGEV_M_INT] & ~ext_or_wait & irq_allow;
  assign int_only    = mode[`DBGEV_M_INT] & ~ext_or_wait & ~irq_allow;
  assign trace_only  = mode[`DBGEV_M_TRACE] & ~ext_or_wait & ~mode[`DBGEV_M_INT];
  assign any_mode    = ext_or_wait | mode[`DBGEV_M_INT] | mode[`DBGEV_M_TRACE];

  // Data value comparison of the accessed lanes against one reference word
  function automatic logic value_hit(input logic [1:0]  cmode,
                                     input logic [3:0]  be,
                                     input logic [31:0] ref_word,
                                     input logic [3:0]  lanes,
                                     input logic [31:0] data);
    logic [3:0] eq;
    logic       hit;
    eq  = 4'h0;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      eq[i] = lanes[i] & (data[31-8*i -: 8] == ref_word[31-8*i -: 8]);
    end
    unique case (cmode)
      `DBGEV_CMP_AND:   hit = ((be & ~eq) == 4'h0);
      `DBGEV_CMP_OR:    hit = |(be & eq);
      `DBGEV_CMP_ANDOR: hit = ((be[1:0] != 2'h0) & ((be[1:0] & ~eq[1:0]) == 2'h0)) |
                              ((be[3:2] != 2'h0) & ((be[3:2] & ~eq[3:2]) == 2'h0));
      default:          hit = 1'b0;
    endcase
    return hit & (be != 4'h0);
  endfunction

  // Which accesses may raise a value-compare event at all
  logic acc_ok;
  always_comb begin
    acc_ok = 1'b0;
    if (acc.valid) begin
      unique case (acc.op)
        dbgev_pkg::DBGEV_OP_LOAD,
        dbgev_pkg::DBGEV_OP_STORE:     acc_ok = 1'b1;
        dbgev_pkg::DBGEV_OP_LINE_ZERO: acc_ok = 1'b1;
        dbgev_pkg::DBGEV_OP_STCOND:    acc_ok = acc.resv_held;
        dbgev_pkg::DBGEV_OP_STRING:    acc_ok = ~acc.count_zero;
        default:                       acc_ok = 1'b0;
      endcase
    end
  end

  // Per-comparator value events for this single access
  logic [1:0] vc_hit;
  logic [3:0] vc_set;
  logic       vc_any;
  logic       vc_sync;
  logic       vc_async;

  assign vc_hit[0] = acc_ok & acc.addr_hit[0] &
                     value_hit(value_compare_control_reg[`DBGEV_VC_M1 +: 2],
                               value_compare_control_reg[`DBGEV_VC_BE1 +: 4],
                               value1, acc.lanes, acc.data);
  assign vc_hit[1] = acc_ok & acc.addr_hit[1] &
                     value_hit(value_compare_control_reg[`DBGEV_VC_M2 +: 2],
                               value_compare_control_reg[`DBGEV_VC_BE2 +: 4],
                               value2, acc.lanes, acc.data);

  // Shared read and write status bits of the address comparators
  assign vc_set[0] = vc_hit[0] & ~acc.is_write & debug_event_enable_reg[`DBGEV_B_C1R];
  assign vc_set[1] = vc_hit[0] &  acc.is_write & debug_event_enable_reg[`DBGEV_B_C1W];
  assign vc_set[2] = vc_hit[1] & ~acc.is_write & debug_event_enable_reg[`DBGEV_B_C2R];
  assign vc_set[3] = vc_hit[1] &  acc.is_write & debug_event_enable_reg[`DBGEV_B_C2W];

  assign vc_any   = (|vc_set) & any_mode;
  assign vc_sync  = vc_any & ~value_compare_control_reg[`DBGEV_VC_ASYNC];
  assign vc_async = vc_any &  value_compare_control_reg[`DBGEV_VC_ASYNC];

  // Instruction events
  logic is_exit;
  logic branch_ev;
  logic trap_ev;
  logic exit_ev;
  logic instr_ev;

  assign is_exit   = instr.valid & ((instr.op == dbgev_pkg::DBGEV_OP_RFI) |
                                    (instr.op == dbgev_pkg::DBGEV_OP_RFCI) |
                                    (instr.op == dbgev_pkg::DBGEV_OP_RFMCI));
  assign branch_ev = debug_event_enable_reg[`DBGEV_B_BRANCH] & instr.valid & instr.cond_ok &
                     (instr.op == dbgev_pkg::DBGEV_OP_BRANCH) &
                     (ext_or_wait | int_allow | trace_only);
  assign trap_ev   = debug_event_enable_reg[`DBGEV_B_TRAP] & instr.valid & instr.cond_ok &
                     (instr.op == dbgev_pkg::DBGEV_OP_TRAP) & any_mode;
  assign exit_ev   = debug_event_enable_reg[`DBGEV_B_EXIT] & is_exit &
                     (ext_or_wait | int_allow | trace_only |
                      (int_only & (instr.op == dbgev_pkg::DBGEV_OP_RFI)));
  assign instr_ev  = branch_ev | trap_ev | exit_ev;

  // Response to this cycle's events
  dbgev_pkg::dbgev_action_t next_action;
  logic                     next_impr;
  logic                     next_pending_set;
  always_comb begin
    next_action            = '0;
    next_impr              = 1'b0;
    next_pending_set       = 1'b0;
    next_action.pc         = instr_ev ? instr.pc : acc.pc;
    next_action.trace_kind = {vc_set, exit_ev, trap_ev, branch_ev};
    if (instr_ev | vc_any) begin
      if (ext_or_wait) begin
        // Stop at the offending instruction
        next_action.suppress = instr_ev | vc_sync;
        next_action.stop     = 1'b1;
      end else if (int_allow) begin
        // Precise debug interrupt, or imprecise for an asynchronous compare
        next_action.suppress  = instr_ev | vc_sync;
        next_action.debug_irq = 1'b1;
        next_impr             = vc_async & ~instr_ev;
      end else if (int_only) begin
        // Interrupts blocked: record imprecisely, interrupt later
        next_impr            = 1'b1;
        next_pending_set     = 1'b1;
        next_action.suppress = trap_ev;
        next_action.prog_irq = trap_ev;
      end else begin
        // Trace only: report, never interfere
        next_action.trace = 1'b1;
      end
    end
  end

  // Status set wins over a software clear in the same cycle
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic       status_wr;
  logic       apb_done;

  assign apb_done   = psel & penable & pready;
  assign status_wr  = apb_done & pwrite & (paddr == `DBGEV_OFS_STATUS);
  assign status_clr = status_wr ? pwdata[7:0] : 8'h00;
  assign status_set = {next_impr, vc_set & {4{any_mode}}, exit_ev, trap_ev, branch_ev};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_status_reg <= 8'h00;
    end else begin
      debug_status_reg <= (debug_status_reg & ~status_clr) | status_set;
    end
  end

  // Action outputs, one cycle after the attempt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      action <= '0;
    end else begin
      action <= next_action;
    end
  end

  // Saved address for the debug interrupt handler
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      critical_save_pc <= `DBGEV_RST_ZERO;
    end else if (next_action.debug_irq) begin
      critical_save_pc <= next_action.pc;
    end
  end

  // Delayed interrupt once interrupts are allowed and status still holds an event
  logic fire_delayed;
  assign fire_delayed = pending & irq_allow & ((debug_status_reg & `DBGEV_EV_MASK) != 8'h00) &
                        mode[`DBGEV_M_INT] & ~ext_or_wait;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pending     <= 1'b0;
      delayed_irq <= 1'b0;
    end else begin
      delayed_irq <= fire_delayed;
      if (next_pending_set) begin
        pending <= 1'b1;
      end else if (fire_delayed | ((debug_status_reg & `DBGEV_EV_MASK) == 8'h00)) begin
        pending <= 1'b0;
      end
    end
  end

  // Register address decode
  function automatic logic mapped(input logic [7:0] a);
    return (a == `DBGEV_OFS_ENABLE) | (a == `DBGEV_OFS_MODE) | (a == `DBGEV_OFS_VCCTL) |
           (a == `DBGEV_OFS_VALUE1) | (a == `DBGEV_OFS_VALUE2) | (a == `DBGEV_OFS_STATUS) |
           (a == `DBGEV_OFS_SAVEPC);
  endfunction

  // APB handshake: one wait state, answer registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `DBGEV_RST_ZERO;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      if (psel & penable & ~pready & ~pwrite) begin
        unique case (paddr)
          `DBGEV_OFS_ENABLE: prdata <= {24'h000000, debug_event_enable_reg};
          `DBGEV_OFS_MODE:   prdata <= {28'h0000000, mode};
          `DBGEV_OFS_VCCTL:  prdata <= {16'h0000, value_compare_control_reg};
          `DBGEV_OFS_VALUE1: prdata <= value1;
          `DBGEV_OFS_VALUE2: prdata <= value2;
          `DBGEV_OFS_STATUS: prdata <= {24'h000000, debug_status_reg};
          `DBGEV_OFS_SAVEPC: prdata <= critical_save_pc;
          default:           prdata <= `DBGEV_RST_ZERO;
        endcase
      end
    end
  end

  // Writable control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_event_enable_reg    <= 8'h00;
      mode                      <= 4'h0;
      value_compare_control_reg <= 16'h0000;
      value1                    <= `DBGEV_RST_ZERO;
      value2                    <= `DBGEV_RST_ZERO;
    end else if (apb_done & pwrite) begin
      unique case (paddr)
        `DBGEV_OFS_ENABLE: debug_event_enable_reg    <= {1'b0, pwdata[6:0]};
        `DBGEV_OFS_MODE:   mode                      <= pwdata[3:0];
        `DBGEV_OFS_VCCTL:  value_compare_control_reg <= pwdata[15:0];
        `DBGEV_OFS_VALUE1: value1                    <= pwdata;
        `DBGEV_OFS_VALUE2: value2                    <= pwdata;
        default:           value1                    <= value1;
      endcase
    end
  end

endmodule

// >>> verification/dbgev_detect_checker.sv
`timescale 1ns/100ps
module dbgev_detect_checker (
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic                     pready,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  input wire logic                     break_interrupt_allow,
  input wire dbgev_pkg::dbgev_instr_t  instr,
  input wire dbgev_pkg::dbgev_access_t acc,
  input wire dbgev_pkg::dbgev_action_t action,
  input wire logic                     delayed_irq
);
  logic [3:0] mode_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Shadow of the mode register from completed bus writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 4'h0;
    end else if (psel && penable && pready && pwrite && paddr == 8'h04) begin
      mode_q <= pwdata[3:0];
    end
  end
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bus answer late");
  // An asynchronous value compare may stop without suppressing; a stop on an instruction event always suppresses
  property p_stop_sup; action.stop |-> !action.trace && (action.suppress || action.trace_kind[2:0] == 3'h0); endproperty
  a_stop_sup: assert property (p_stop_sup) else $error("stop without suppress");
  property p_stop_pc; action.stop && action.trace_kind[2:0] != 3'h0 |-> action.pc == $past(instr.pc); endproperty
  a_stop_pc: assert property (p_stop_pc) else $error("stop pc wrong");
  property p_dbg_pc; action.debug_irq && action.trace_kind[2:0] != 3'h0 |-> action.pc == $past(instr.pc); endproperty
  a_dbg_pc: assert property (p_dbg_pc) else $error("debug pc wrong");
  property p_trace_run; action.trace |-> !action.suppress && !action.stop && !action.debug_irq; endproperty
  a_trace_run: assert property (p_trace_run) else $error("trace halted core");
  property p_brt_block;
    instr.valid && instr.op == dbgev_pkg::DBGEV_OP_BRANCH && mode_q == 4'h4 && !break_interrupt_allow && !acc.valid
      |=> !(action.suppress || action.stop || action.debug_irq || action.trace);
  endproperty
  a_brt_block: assert property (p_brt_block) else $error("blocked branch raised event");
  property p_crit_block;
    instr.valid && instr.op inside {dbgev_pkg::DBGEV_OP_RFCI, dbgev_pkg::DBGEV_OP_RFMCI} && mode_q == 4'h4
      && !break_interrupt_allow && !acc.valid |=> !(action.suppress || action.debug_irq || action.trace);
  endproperty
  a_crit_block: assert property (p_crit_block) else $error("critical return raised event");
  property p_ext_first; $past(mode_q[1:0]) != 2'h0 |-> !action.trace && !action.prog_irq; endproperty
  a_ext_first: assert property (p_ext_first) else $error("halt mode not first");
  property p_prog_trap; action.prog_irq |-> action.suppress && $past(instr.op) == dbgev_pkg::DBGEV_OP_TRAP; endproperty
  a_prog_trap: assert property (p_prog_trap) else $error("program irq without trap");
  property p_delay_allow; delayed_irq |-> $past(break_interrupt_allow) && $past(mode_q[2]); endproperty
  a_delay_allow: assert property (p_delay_allow) else $error("delayed irq while blocked");
  c_stop: cover property (action.stop);
  c_trace: cover property (action.trace);
  c_delay: cover property (delayed_irq);
endmodule

bind dbgev_detect dbgev_detect_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .instr(instr), .acc(acc),
  .break_interrupt_allow(break_interrupt_allow), .action(action), .delayed_irq(delayed_irq)
);

// >>> verification/dbgev_tool_model.sv
`timescale 1ns/100ps
module dbgev_tool_model (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire dbgev_pkg::dbgev_action_t action,
  output logic [7:0]                    n_stop,
  output logic [7:0]                    n_trace
);
  // Halts seen by the tool
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_stop <= 8'h00;
    end else if (action.stop) begin
      n_stop <= n_stop + 8'h01;
    end
  end
  // Trace records seen by the tool
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_trace <= 8'h00;
    end else if (action.trace) begin
      n_trace <= n_trace + 8'h01;
    end
  end
endmodule

// >>> verification/dbgev_detect_bench.sv
`timescale 1ns/100ps
module dbgev_detect_bench;
  logic                     clk_sys = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0;
  logic                     pready;
  logic [31:0]              prdata;
  logic                     pslverr;
  logic                     break_interrupt_allow = 1'b0;
  dbgev_pkg::dbgev_instr_t  instr = '0;
  dbgev_pkg::dbgev_access_t acc = '0;
  dbgev_pkg::dbgev_action_t action;
  logic                     delayed_irq;
  logic [7:0]               n_stop;
  logic [7:0]               n_trace;
  logic [31:0]              rd;
  logic                     err;
  logic [31:0]              pcn = 32'h1000;
  int                       n_mismatch = 0;
  int                       n_checks = 0;
  int                       exp_stop = 0;
  int                       exp_trace = 0;
  localparam dbgev_pkg::dbgev_instr_t  no_i = '0;
  localparam dbgev_pkg::dbgev_access_t no_a = '0;

  always #4 clk_sys = ~clk_sys;

  dbgev_detect dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .instr(instr), .acc(acc),
    .break_interrupt_allow(break_interrupt_allow), .action(action), .delayed_irq(delayed_irq)
  );
  dbgev_tool_model tool (.clk_sys(clk_sys), .rst_n(rst_n), .action(action), .n_stop(n_stop), .n_trace(n_trace));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; read data and error taken at the ready edge; a hang is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Instruction attempt with the next pc
  function automatic dbgev_pkg::dbgev_instr_t fi(input logic [3:0] op, input logic c);
    pcn = pcn + 32'h4;
    fi = '{valid: 1'b1, op: dbgev_pkg::dbgev_op_t'(op), cond_ok: c, pc: pcn};
  endfunction

  // Storage access hitting comparator 1; f is {write, reservation, zero count, data mismatch}
  function automatic dbgev_pkg::dbgev_access_t fa(input logic [3:0] op, input logic [3:0] f);
    pcn = pcn + 32'h4;
    fa = '{valid: 1'b1, op: dbgev_pkg::dbgev_op_t'(op), is_write: f[3], resv_held: f[2], count_zero: f[1],
           addr_hit: 2'h1, lanes: 4'hf, data: {31'h0, f[0]}, pc: pcn};
  endfunction

  // Clear status, set mode, send one event; ef is {suppress, stop, debug, program, trace}
  task automatic ev(input logic [3:0] m, input logic al, input dbgev_pkg::dbgev_instr_t i,
                    input dbgev_pkg::dbgev_access_t a, input logic [4:0] ef, input logic [7:0] es);
    apb(1'b1, 8'h14, 32'hff);
    apb(1'b1, 8'h04, {28'h0, m});
    @(posedge clk_sys);
    break_interrupt_allow <= al;
    instr <= i;
    acc <= a;
    @(posedge clk_sys);
    instr <= '0;
    acc <= '0;
    @(posedge clk_sys);
    chk({27'h0, action.suppress, action.stop, action.debug_irq, action.prog_irq, action.trace}, {27'h0, ef});
    if (ef != 5'h0) chk(action.pc, i.valid ? i.pc : a.pc);
    if (ef[0]) chk({25'h0, action.trace_kind}, {25'h0, es[6:0]});
    exp_stop += ef[3];
    exp_trace += ef[0];
    rdchk(8'h14, {24'h0, es});
  endtask

  // Raise interrupt allow and look for the delayed interrupt
  task automatic wait_delay(input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge clk_sys);
    break_interrupt_allow <= 1'b1;
    repeat (8) begin
      @(posedge clk_sys);
      seen = seen | delayed_irq;
    end
    chk({31'h0, seen}, {31'h0, e});
    break_interrupt_allow <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      rdchk(8'(k * 4), 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    rdchk(8'h00, 32'h7f);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    rdchk(8'h04, 32'hf);
    apb(1'b1, 8'h08, 32'h10f0);
    ev(4'h1, 1'b0, fi(4'h1, 1'b1), no_a, 5'h18, 8'h01);
    ev(4'h2, 1'b0, fi(4'h2, 1'b1), no_a, 5'h18, 8'h02);
    ev(4'h1, 1'b0, fi(4'h4, 1'b1), no_a, 5'h18, 8'h04);
    ev(4'h4, 1'b1, fi(4'h1, 1'b1), no_a, 5'h14, 8'h01);
    rdchk(8'h18, pcn);
    apb(1'b1, 8'h18, 32'hffff_ffff);
    rdchk(8'h18, pcn);
    ev(4'h4, 1'b1, fi(4'h2, 1'b1), no_a, 5'h14, 8'h02);
    ev(4'h4, 1'b1, fi(4'h5, 1'b1), no_a, 5'h14, 8'h04);
    ev(4'h4, 1'b0, fi(4'h1, 1'b1), no_a, 5'h00, 8'h00);
    ev(4'h4, 1'b0, fi(4'h4, 1'b1), no_a, 5'h00, 8'h00);
    ev(4'h4, 1'b0, fi(4'h5, 1'b1), no_a, 5'h00, 8'h00);
    ev(4'h4, 1'b0, fi(4'h2, 1'b1), no_a, 5'h12, 8'h82);
    wait_delay(1'b1);
    ev(4'h4, 1'b0, fi(4'h3, 1'b1), no_a, 5'h00, 8'h84);
    apb(1'b1, 8'h14, 32'hff);
    wait_delay(1'b0);
    ev(4'h8, 1'b0, fi(4'h1, 1'b1), no_a, 5'h01, 8'h01);
    ev(4'h8, 1'b0, fi(4'h2, 1'b1), no_a, 5'h01, 8'h02);
    ev(4'h8, 1'b0, fi(4'h3, 1'b1), no_a, 5'h01, 8'h04);
    ev(4'hd, 1'b1, fi(4'h1, 1'b1), no_a, 5'h18, 8'h01);
    ev(4'h1, 1'b0, fi(4'h1, 1'b0), no_a, 5'h00, 8'h00);
    ev(4'h1, 1'b0, fi(4'h2, 1'b0), no_a, 5'h00, 8'h00);
    ev(4'h1, 1'b0, no_i, fa(4'h7, 4'h8), 5'h18, 8'h10);
    ev(4'h1, 1'b0, no_i, fa(4'h6, 4'h0), 5'h18, 8'h08);
    ev(4'h1, 1'b0, no_i, fa(4'h7, 4'h9), 5'h00, 8'h00);
    ev(4'h1, 1'b0, no_i, fa(4'h8, 4'h8), 5'h18, 8'h10);
    ev(4'h1, 1'b0, no_i, fa(4'h9, 4'h8), 5'h00, 8'h00);
    ev(4'h1, 1'b0, no_i, fa(4'ha, 4'h8), 5'h00, 8'h00);
    ev(4'h1, 1'b0, no_i, fa(4'ha, 4'hc), 5'h18, 8'h10);
    ev(4'h1, 1'b0, no_i, fa(4'hb, 4'ha), 5'h00, 8'h00);
    ev(4'h1, 1'b0, no_i, fa(4'hb, 4'h8), 5'h18, 8'h10);
    ev(4'h4, 1'b1, no_i, fa(4'h7, 4'h8), 5'h14, 8'h10);
    apb(1'b1, 8'h08, 32'h10f1);
    ev(4'h4, 1'b1, no_i, fa(4'h7, 4'h8), 5'h04, 8'h90);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h14, 32'hff);
    @(posedge clk_sys);
    acc <= fa(4'h7, 4'h9);
    @(posedge clk_sys);
    acc <= fa(4'h7, 4'h8);
    @(posedge clk_sys);
    acc <= '0;
    @(posedge clk_sys);
    chk(action.pc, pcn);
    // Asynchronous compare in halt mode: stop without suppressing the access
    chk({30'h0, action.stop, action.suppress}, 32'h2);
    exp_stop += 1;
    rdchk(8'h14, 32'h10);
    chk({24'h0, n_stop}, 32'(exp_stop));
    chk({24'h0, n_trace}, 32'(exp_trace));
    stop_test;
  end

  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
endmodule
